// file: core/jtl_pkg.sv
// Constants and types shared by the link transmitter lane configuration block.
// Assumes a 32-bit APB master and word-aligned register indices.
package jtl_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_FRAME_FMT = 12'h592;
  localparam logic [11:0] IDX_CKSUM0 = 12'h5a0;
  localparam logic [11:0] IDX_CKSUM1 = 12'h5a1;
  localparam logic [11:0] IDX_LANE_PD = 12'h5b0;
  localparam logic [11:0] IDX_OUT0_SEL = 12'h5b2;
  localparam logic [11:0] IDX_OUT1_SEL = 12'h5b3;
  localparam logic [11:0] IDX_OUT0_SWING = 12'h5c0;
  localparam logic [11:0] IDX_OUT1_SWING = 12'h5c1;

  // ----------------------------------------------------------------
  // Field positions and writable masks
  // ----------------------------------------------------------------
  localparam int HD_BIT = 7;
  localparam int CF_W = 5;
  localparam int PD0_BIT = 0;
  localparam int PD1_BIT = 2;
  localparam int SEL_W = 3;
  localparam int SWING_W = 3;
  localparam logic [7:0] PD_WR_MASK = 8'hff;
  localparam logic [7:0] SEL_WR_MASK = 8'h77;
  localparam logic [7:0] SWING_WR_MASK = 8'h07;
  localparam logic [2:0] SWING_FULL = 3'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_HD = 1'b0;
  localparam logic [4:0] RST_CF = 5'h00;
  localparam logic [7:0] RST_LANE_PD = 8'hfa;
  localparam logic [7:0] RST_OUT0_SEL = 8'h00;
  localparam logic [7:0] RST_OUT1_SEL = 8'h11;
  localparam logic [7:0] RST_SWING = 8'h01;
  localparam logic [7:0] RST_CKSUM0 = 8'hc3;
  localparam logic [7:0] RST_CKSUM1 = 8'hc4;
  localparam logic [1:0] RST_LANE0 = 2'h0;
  localparam logic [1:0] RST_LANE1 = 2'h1;

  // Number of configuration octets summed into each lane checksum
  localparam int CFG_BYTES = 11;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hd;
    logic [4:0] cf;
    logic [7:0] lane_pd;
    logic [7:0] out0_sel;
    logic [7:0] out1_sel;
    logic [7:0] out0_swing;
    logic [7:0] out1_swing;
    logic [31:0] rdata;
    logic slverr;
  } jtl_regs_t;

  typedef struct packed {
    logic power_down;
    logic [1:0] lane;
    logic swing_reduced;
  } jtl_drv_t;

  typedef struct packed {
    logic [7:0] sum;
  } jtl_sum_t;

endpackage

// file: core/jtl_lane_if.sv
// Configuration of one physical serial output, from register bank to driver control.
// Assumes both ends run on the register clock.
`timescale 1ns/1ps
`default_nettype none
interface jtl_lane_if;
  logic [2:0] lane_sel;
  logic [2:0] swing;
  logic power_down;
  modport cfg (output lane_sel, output swing, output power_down);
  modport drv (input lane_sel, input swing, input power_down);
endinterface
`default_nettype wire

// file: core/jtl_sum.sv
// Modulo-256 sum of one lane's configuration octets, registered.
// Assumes the octets are stable or change synchronously to clk.
`timescale 1ns/1ps
`default_nettype none
module jtl_sum #(
  parameter logic [7:0] RST_SUM = 8'h00
) (
  input wire logic clk, // Register clock
  input wire logic rstn, // Async reset, active low
  input wire logic [jtl_pkg::CFG_BYTES*8-1:0] cfg_bytes, // Lane configuration octets
  output logic [7:0] sum // Registered checksum
);
  jtl_pkg::jtl_sum_t st;
  jtl_pkg::jtl_sum_t next_st;
  logic [15:0] wide_sum;

  always_comb
  begin
    next_st = st;
    next_st.sum = 8'h00;
    for (int i = 0; i < jtl_pkg::CFG_BYTES; i++)
    begin
      next_st.sum = next_st.sum + cfg_bytes[i*8 +: 8];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st <= '{sum: RST_SUM};
    else
      st <= next_st;
  end

  assign sum = st.sum;

  // Wide reference sum, only read by the check below
  always_comb
  begin
    wide_sum = 16'h0000;
    for (int i = 0; i < jtl_pkg::CFG_BYTES; i++)
    begin
      wide_sum = wide_sum + {8'h00, cfg_bytes[i*8 +: 8]};
    end
  end

  sum_mod256_a:
  // The edge that releases reset still loads the reset sum, so start one edge later
  assert property (@(posedge clk) disable iff (!rstn)
    rstn |=> sum == $past(wide_sum[7:0]))
    else $error("checksum is not the modulo-256 sum of the lane octets");

endmodule // jtl_sum
`default_nettype wire

// file: core/jtl_lane_drv.sv
// Registered control of one physical serial output: power, source lane, swing.
// Assumes the configuration arrives through the drv side of a lane interface.
`timescale 1ns/1ps
`default_nettype none
module jtl_lane_drv #(
  parameter logic [1:0] RST_LANE = 2'h0
) (
  input wire logic clk, // Register clock
  input wire logic rstn, // Async reset, active low
  jtl_lane_if.drv lif, // Configuration from the register bank
  output logic power_down, // Lane forced off
  output logic [1:0] lane, // Logical lane driven onto this output
  output logic swing_reduced // Reduced swing selected
);
  jtl_pkg::jtl_drv_t st;
  jtl_pkg::jtl_drv_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.power_down = lif.power_down;
    // Codes above three alias onto the low two bits
    next_st.lane = lif.lane_sel[1:0];
    next_st.swing_reduced = (lif.swing != jtl_pkg::SWING_FULL);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st <= '{power_down: 1'b0, lane: RST_LANE, swing_reduced: 1'b1};
    else
      st <= next_st;
  end

  assign power_down = st.power_down;
  assign lane = st.lane;
  assign swing_reduced = st.swing_reduced;

  swing_code_a:
  assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> swing_reduced == ($past(lif.swing) != 3'h0))
    else $error("swing select does not follow the swing code");

endmodule // jtl_lane_drv
`default_nettype wire

// file: core/jtl_lane_cfg.sv
// Link transmitter lane configuration and status registers behind an APB slave.
// Assumes a single clock, link parameters synchronous to it, zero-wait-state bus.
//
// Contract
// - Bit 7 of frame format status reads the high density flag, reset 0.
// - Bits 4:0 of that register read control words per frame, raw, reset 0.
// - Lane 0 checksum is the modulo-256 sum of its configuration octets, read-only.
// - Lane 1 checksum is a separate modulo-256 sum of its octets, read-only.
// - Power-down bit 0 set forces physical lane 0 off; resets to 0.
// - Power-down bit 2 set forces physical lane 1 off; other bits reset to 1.
// - Output 0 lane field 2:0 picks logical lane 0 to 3; resets to 0.
// - Output 1 lane field uses same codes; resets to logical lane 1.
// - Each output swing field resets 1; 0 full swing, 1 reduced swing.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module jtl_lane_cfg (
  input wire logic clk, // Register clock, 100 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [jtl_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [jtl_pkg::DATA_W-1:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [jtl_pkg::DATA_W-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic high_density_flag, // High density format active
  input wire logic [4:0] control_words_per_frame, // Control words per frame
  input wire logic [jtl_pkg::CFG_BYTES*8-1:0] lane0_cfg_bytes, // Lane 0 octets
  input wire logic [jtl_pkg::CFG_BYTES*8-1:0] lane1_cfg_bytes, // Lane 1 octets
  output logic serial_output_zero_power_down, // Output 0 forced off
  output logic [1:0] serial_output_zero_lane, // Logical lane on output 0
  output logic serial_output_zero_swing_reduced, // Output 0 reduced swing
  output logic serial_output_one_power_down, // Output 1 forced off
  output logic [1:0] serial_output_one_lane, // Logical lane on output 1
  output logic serial_output_one_swing_reduced // Output 1 reduced swing
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  jtl_pkg::jtl_regs_t st;
  jtl_pkg::jtl_regs_t next_st;
  logic [11:0] idx;
  logic in_range;
  logic setup_phase;
  logic access_phase;
  logic wr_en;
  logic mapped;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic [7:0] cksum0;
  logic [7:0] cksum1;

  jtl_lane_if out0_if ();
  jtl_lane_if out1_if ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign idx = paddr[13:2];
  assign in_range = (paddr[15:14] == 2'h0);
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  // Narrow registers take only the low byte lane
  assign wr_en = access_phase && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];

  always_comb
  begin
    mapped = in_range;
    rd_byte = 8'h00;
    case (idx)
      jtl_pkg::IDX_FRAME_FMT: rd_byte = {st.hd, 2'b00, st.cf};
      jtl_pkg::IDX_CKSUM0: rd_byte = cksum0;
      jtl_pkg::IDX_CKSUM1: rd_byte = cksum1;
      jtl_pkg::IDX_LANE_PD: rd_byte = st.lane_pd;
      jtl_pkg::IDX_OUT0_SEL: rd_byte = st.out0_sel & jtl_pkg::SEL_WR_MASK;
      jtl_pkg::IDX_OUT1_SEL: rd_byte = st.out1_sel & jtl_pkg::SEL_WR_MASK;
      jtl_pkg::IDX_OUT0_SWING: rd_byte = st.out0_swing & jtl_pkg::SWING_WR_MASK;
      jtl_pkg::IDX_OUT1_SWING: rd_byte = st.out1_swing & jtl_pkg::SWING_WR_MASK;
      default: mapped = 1'b0;
    endcase
    if (!mapped)
    begin
      rd_byte = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // Status is resampled every cycle so reads see the live link format
    next_st.hd = high_density_flag;
    next_st.cf = control_words_per_frame;
    // Read data is captured in the setup cycle, ready in the access cycle
    if (setup_phase)
    begin
      next_st.rdata = {24'h00_0000, rd_byte};
      next_st.slverr = !mapped;
    end
    if (wr_en && mapped)
    begin
      case (idx)
        jtl_pkg::IDX_LANE_PD:
          next_st.lane_pd = wbyte & jtl_pkg::PD_WR_MASK;
        jtl_pkg::IDX_OUT0_SEL:
          next_st.out0_sel = wbyte & jtl_pkg::SEL_WR_MASK;
        jtl_pkg::IDX_OUT1_SEL:
          next_st.out1_sel = wbyte & jtl_pkg::SEL_WR_MASK;
        jtl_pkg::IDX_OUT0_SWING:
          next_st.out0_swing = wbyte & jtl_pkg::SWING_WR_MASK;
        jtl_pkg::IDX_OUT1_SWING:
          next_st.out1_swing = wbyte & jtl_pkg::SWING_WR_MASK;
        default:
          next_st.lane_pd = st.lane_pd;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '{hd: jtl_pkg::RST_HD,
              cf: jtl_pkg::RST_CF,
              lane_pd: jtl_pkg::RST_LANE_PD,
              out0_sel: jtl_pkg::RST_OUT0_SEL,
              out1_sel: jtl_pkg::RST_OUT1_SEL,
              out0_swing: jtl_pkg::RST_SWING,
              out1_swing: jtl_pkg::RST_SWING,
              rdata: 32'h0000_0000,
              slverr: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  // No wait states: every access completes in its first access cycle
  assign pready = access_phase;
  assign pslverr = access_phase && st.slverr;
  assign prdata = st.rdata;

  // ----------------------------------------------------------------
  // Lane checksums
  // ----------------------------------------------------------------
  jtl_sum #(
    .RST_SUM(jtl_pkg::RST_CKSUM0)
  ) u_sum0 (
    .clk(clk),
    .rstn(rstn),
    .cfg_bytes(lane0_cfg_bytes),
    .sum(cksum0)
  );

  jtl_sum #(
    .RST_SUM(jtl_pkg::RST_CKSUM1)
  ) u_sum1 (
    .clk(clk),
    .rstn(rstn),
    .cfg_bytes(lane1_cfg_bytes),
    .sum(cksum1)
  );

  // ----------------------------------------------------------------
  // Physical output control
  // ----------------------------------------------------------------
  // Duplicate lane mappings are not blocked; keeping them unique is up to software
  assign out0_if.power_down = st.lane_pd[jtl_pkg::PD0_BIT];
  assign out0_if.lane_sel = st.out0_sel[jtl_pkg::SEL_W-1:0];
  assign out0_if.swing = st.out0_swing[jtl_pkg::SWING_W-1:0];
  assign out1_if.power_down = st.lane_pd[jtl_pkg::PD1_BIT];
  assign out1_if.lane_sel = st.out1_sel[jtl_pkg::SEL_W-1:0];
  assign out1_if.swing = st.out1_swing[jtl_pkg::SWING_W-1:0];

  jtl_lane_drv #(
    .RST_LANE(jtl_pkg::RST_LANE0)
  ) u_drv0 (
    .clk(clk),
    .rstn(rstn),
    .lif(out0_if),
    .power_down(serial_output_zero_power_down),
    .lane(serial_output_zero_lane),
    .swing_reduced(serial_output_zero_swing_reduced)
  );

  jtl_lane_drv #(
    .RST_LANE(jtl_pkg::RST_LANE1)
  ) u_drv1 (
    .clk(clk),
    .rstn(rstn),
    .lif(out1_if),
    .power_down(serial_output_one_power_down),
    .lane(serial_output_one_lane),
    .swing_reduced(serial_output_one_swing_reduced)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  hd_status_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (setup_phase && in_range && idx == 12'h592) |=>
      prdata[7] == $past(high_density_flag, 2))
    else $error("status bit 7 does not show the high density flag");

  cf_status_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (setup_phase && in_range && idx == 12'h592) |=>
      (prdata[4:0] == $past(control_words_per_frame, 2)) && (prdata[6:5] == 2'b00))
    else $error("status field does not show control words per frame");

  cksum0_read_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (setup_phase && in_range && idx == 12'h5a0) |=>
      (prdata == {24'h00_0000, $past(cksum0)}) && pready && !pslverr)
    else $error("lane 0 checksum read returned wrong data");

  cksum1_read_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (setup_phase && in_range && idx == 12'h5a1) |=>
      (prdata == {24'h00_0000, $past(cksum1)}) && pready && !pslverr)
    else $error("lane 1 checksum read returned wrong data");

  lane0_pd_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (wr_en && in_range && idx == 12'h5b0) |->
      ##2 serial_output_zero_power_down == $past(pwdata[0], 2))
    else $error("lane 0 power-down does not follow bit 0");

  lane1_pd_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (wr_en && in_range && idx == 12'h5b0) |->
      ##2 serial_output_one_power_down == $past(pwdata[2], 2))
    else $error("lane 1 power-down does not follow bit 2");

  out0_sel_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (wr_en && in_range && idx == 12'h5b2) |->
      ##2 serial_output_zero_lane == $past(pwdata[1:0], 2))
    else $error("output 0 lane does not follow its select field");

  out1_sel_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (wr_en && in_range && idx == 12'h5b3) |->
      ##2 serial_output_one_lane == $past(pwdata[1:0], 2))
    else $error("output 1 lane does not follow its select field");

  swing_write_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (wr_en && in_range && idx == 12'h5c1) |->
      ##2 serial_output_one_swing_reduced == ($past(pwdata[2:0], 2) != 3'h0))
    else $error("output 1 swing does not follow its swing field");

  unmapped_err_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (setup_phase && !mapped) |=> pready && pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped access not answered with an error");

  swing0_write_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (wr_en && in_range && idx == 12'h5c0) |->
      ##2 serial_output_zero_swing_reduced == ($past(pwdata[2:0], 2) != 3'h0))
    else $error("output 0 swing does not follow its swing field");

  swing1_store_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (wr_en && in_range && idx == 12'h5c1) |=>
      st.out1_swing == ($past(pwdata[7:0]) & 8'h07))
    else $error("output 1 swing field not stored masked");

  swing_read_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (setup_phase && in_range && (idx == 12'h5c0 || idx == 12'h5c1)) |=>
      prdata[31:3] == 29'h0000_0000)
    else $error("swing register read shows reserved bits");

  pd_store_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (wr_en && in_range && idx == 12'h5b0) |=> st.lane_pd == $past(pwdata[7:0]))
    else $error("power-down register did not take the byte");

  pd_strobe_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (access_phase && pwrite && !pstrb[0] && in_range && idx == 12'h5b0) |=>
      $stable(st.lane_pd))
    else $error("power-down register changed on unstrobed write");

  pd_read_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (setup_phase && in_range && idx == 12'h5b0) |=>
      prdata == {24'h00_0000, $past(st.lane_pd)})
    else $error("power-down register read returned wrong data");

  sel0_store_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (wr_en && in_range && idx == 12'h5b2) |=>
      st.out0_sel == ($past(pwdata[7:0]) & 8'h77))
    else $error("output 0 select not stored masked");

  sel1_store_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (wr_en && in_range && idx == 12'h5b3) |=>
      st.out1_sel == ($past(pwdata[7:0]) & 8'h77))
    else $error("output 1 select not stored masked");

  sel0_read_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (setup_phase && in_range && idx == 12'h5b2) |=>
      prdata == {24'h00_0000, $past(st.out0_sel) & 8'h77})
    else $error("output 0 select read returned wrong data");

  sel1_read_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (setup_phase && in_range && idx == 12'h5b3) |=>
      prdata == {24'h00_0000, $past(st.out1_sel) & 8'h77})
    else $error("output 1 select read returned wrong data");

  ro_write_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (wr_en && in_range && (idx == 12'h592 || idx == 12'h5a0 || idx == 12'h5a1)) |=>
      $stable(st.lane_pd) && $stable(st.out0_sel) && $stable(st.out1_sel))
    else $error("write to a read-only register changed state");

  range_write_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (access_phase && pwrite && !in_range) |=>
      $stable(st.lane_pd) && $stable(st.out0_sel) && $stable(st.out1_sel))
    else $error("out of range write changed state");

  status_upper_a:
  assert property (@(posedge clk) disable iff (!rstn)
    (setup_phase && in_range && idx == 12'h592) |=> prdata[31:8] == 24'h00_0000)
    else $error("status read shows nonzero upper bits");

endmodule // jtl_lane_cfg
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the link transmitter lane configuration register bank.
// Assumes the APB slave ends each transfer with its own pready; no partner model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [87:0] OCTETS_A = {11{8'hc7}};
  localparam logic [87:0] OCTETS_B = 88'h0123_4567_89ab_cdef_fedc_ba;
  localparam logic [87:0] OCTETS_C = {11{8'hff}};
  localparam int WAIT_MAX = 16;

  logic clk, rstn, psel, penable, pwrite, pready, pslverr, high_density_flag;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [4:0] control_words_per_frame;
  logic [87:0] lane0_cfg_bytes, lane1_cfg_bytes;
  logic pd0, pd1, sw0, sw1;
  logic [1:0] ln0, ln1;
  int miscompares;
  int cmp_count;

  jtl_lane_cfg DUT (
    .clk(clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .high_density_flag(high_density_flag),
    .control_words_per_frame(control_words_per_frame),
    .lane0_cfg_bytes(lane0_cfg_bytes),
    .lane1_cfg_bytes(lane1_cfg_bytes),
    .serial_output_zero_power_down(pd0),
    .serial_output_zero_lane(ln0),
    .serial_output_zero_swing_reduced(sw0),
    .serial_output_one_power_down(pd1),
    .serial_output_one_lane(ln1),
    .serial_output_one_swing_reduced(sw1)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Reporting and comparison
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask

  // Pin group order: pd0, lane0, swing0, pd1, lane1, swing1
  task automatic chk_pins(input logic [7:0] exp);
    cmp_count++;
    if ({pd0, ln0, sw0, pd1, ln1, sw1} !== exp)
    begin
      miscompares++;
      $display("Error at %0t: pins got %h expected %h", $time, {pd0, ln0, sw0, pd1, ln1, sw1}, exp);
    end
  endtask

  function automatic logic [15:0] ba(input logic [11:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // Independent modulo-256 octet sum for the checksum expectation
  function automatic logic [7:0] sum_of(input logic [87:0] b);
    logic [7:0] s;
    s = 8'h00;
    for (int k = 0; k < jtl_pkg::CFG_BYTES; k++)
    begin
      s = s + b[8*k +: 8];
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // APB master
  // ----------------------------------------------------------------
  // Leading edge keeps psel from being driven twice in one time step
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < WAIT_MAX)
    begin
      n++;
      @(posedge clk);
    end
    if (n >= WAIT_MAX)
    begin
      miscompares++;
      $display("Error at %0t: pready got %h expected %h", $time, pready, 1'b1);
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Upper data bytes carry junk that the bank must ignore
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, {24'ha5_a5a5, d}, s, rd, err);
    chk_reg({31'h0000_0000, err}, 32'h0000_0000);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input logic eerr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, 4'hf, rd, err);
    chk_reg(rd, {24'h00_0000, exp});
    chk_reg({31'h0000_0000, err}, {31'h0000_0000, eerr});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] rd;
    logic err;
    logic [1:0] c;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    high_density_flag = 1'b0;
    control_words_per_frame = 5'h00;
    lane0_cfg_bytes = OCTETS_A;
    lane1_cfg_bytes = OCTETS_B;
    miscompares = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk_pins({1'b0, 2'h0, 1'b1, 1'b0, 2'h1, 1'b1});
    rd_chk(ba(jtl_pkg::IDX_FRAME_FMT), 8'h00, 1'b0);
    rd_chk(ba(jtl_pkg::IDX_CKSUM0), sum_of(OCTETS_A), 1'b0);
    rd_chk(ba(jtl_pkg::IDX_CKSUM1), sum_of(OCTETS_B), 1'b0);
    rd_chk(ba(jtl_pkg::IDX_LANE_PD), 8'hfa, 1'b0);
    rd_chk(ba(jtl_pkg::IDX_OUT0_SEL), 8'h00, 1'b0);
    rd_chk(ba(jtl_pkg::IDX_OUT1_SEL), 8'h11, 1'b0);
    rd_chk(ba(jtl_pkg::IDX_OUT0_SWING), 8'h01, 1'b0);
    rd_chk(ba(jtl_pkg::IDX_OUT1_SWING), 8'h01, 1'b0);
    high_density_flag <= 1'b1;
    control_words_per_frame <= 5'h1f;
    rd_chk(ba(jtl_pkg::IDX_FRAME_FMT), 8'h9f, 1'b0);
    high_density_flag <= 1'b0;
    control_words_per_frame <= 5'h0a;
    lane1_cfg_bytes <= OCTETS_C;
    rd_chk(ba(jtl_pkg::IDX_FRAME_FMT), 8'h0a, 1'b0);
    rd_chk(ba(jtl_pkg::IDX_CKSUM1), sum_of(OCTETS_C), 1'b0);
    wr(ba(jtl_pkg::IDX_CKSUM0), 8'h00, 4'hf);
    wr(ba(jtl_pkg::IDX_FRAME_FMT), 8'hff, 4'hf);
    rd_chk(ba(jtl_pkg::IDX_CKSUM0), sum_of(OCTETS_A), 1'b0);
    rd_chk(ba(jtl_pkg::IDX_FRAME_FMT), 8'h0a, 1'b0);
    wr(ba(jtl_pkg::IDX_LANE_PD), 8'hfb, 4'hf);
    repeat (2) @(posedge clk);
    chk_pins({1'b1, 2'h0, 1'b1, 1'b0, 2'h1, 1'b1});
    rd_chk(ba(jtl_pkg::IDX_LANE_PD), 8'hfb, 1'b0);
    wr(ba(jtl_pkg::IDX_LANE_PD), 8'hfe, 4'hf);
    repeat (2) @(posedge clk);
    chk_pins({1'b0, 2'h0, 1'b1, 1'b1, 2'h1, 1'b1});
    // Byte lane 0 not strobed, so the write must not land
    wr(ba(jtl_pkg::IDX_LANE_PD), 8'h00, 4'he);
    rd_chk(ba(jtl_pkg::IDX_LANE_PD), 8'hfe, 1'b0);
    wr(ba(jtl_pkg::IDX_LANE_PD), 8'hfa, 4'hf);
    for (int i = 0; i < 4; i++)
    begin
      c = i[1:0];
      wr(ba(jtl_pkg::IDX_OUT0_SEL), {6'h00, c}, 4'hf);
      wr(ba(jtl_pkg::IDX_OUT1_SEL), {6'h04, ~c}, 4'hf);
      repeat (2) @(posedge clk);
      chk_pins({1'b0, c, 1'b1, 1'b0, ~c, 1'b1});
      rd_chk(ba(jtl_pkg::IDX_OUT0_SEL), {6'h00, c}, 1'b0);
      rd_chk(ba(jtl_pkg::IDX_OUT1_SEL), {6'h04, ~c}, 1'b0);
    end
    wr(ba(jtl_pkg::IDX_OUT0_SWING), 8'h00, 4'hf);
    wr(ba(jtl_pkg::IDX_OUT1_SWING), 8'hff, 4'hf);
    repeat (2) @(posedge clk);
    chk_pins({1'b0, 2'h3, 1'b0, 1'b0, 2'h0, 1'b1});
    rd_chk(ba(jtl_pkg::IDX_OUT0_SWING), 8'h00, 1'b0);
    rd_chk(ba(jtl_pkg::IDX_OUT1_SWING), 8'h07, 1'b0);
    wr(ba(jtl_pkg::IDX_OUT0_SWING), 8'h01, 4'hf);
    wr(ba(jtl_pkg::IDX_OUT1_SWING), 8'h00, 4'hf);
    repeat (2) @(posedge clk);
    chk_pins({1'b0, 2'h3, 1'b1, 1'b0, 2'h0, 1'b0});
    // Unmapped word and out-of-range upper address bits both answer with an error
    rd_chk(ba(12'h5a2), 8'h00, 1'b1);
    rd_chk(ba(jtl_pkg::IDX_LANE_PD) | 16'h4000, 8'h00, 1'b1);
    apb(1'b1, ba(jtl_pkg::IDX_LANE_PD) | 16'h8000, 32'h0000_0000, 4'hf, rd, err);
    chk_reg({31'h0000_0000, err}, 32'h0000_0001);
    rd_chk(ba(jtl_pkg::IDX_LANE_PD), 8'hfa, 1'b0);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
